//--- design/ups_phy_status.v
// Behaviour
// - Three supply comparators encode to 00, 01, 10, 11 by rising threshold.
// - Supply-state change sends a status byte when its edge enable is set.
// - Supply sense and external fault share one pin; only one used.
// - Receive events encode: 00 idle, 01 active, 11 error, 10 disconnect.
// - SYNC signalled by DIR with NXT together, or an active status byte.
// - Receive error: drop NXT, then send status byte with error encoding.
// - Disconnect valid only with both pull-downs; changes send a status byte when their edge enable is set.
// - Both immediate and extended register accesses are supported.
// - DIR rising during a register access aborts it; link retries.
// - Status byte: line 1:0, supply 3:2, event 5:4, cable ID 6, alt 7.
// - Any change on either data line sends a status byte.
`timescale 1ns/1ps
`default_nettype none
`include "ups_regs.vh"

module ups_phy_status #(
    parameter DIR_NXT_START = 1
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // Analog front end status
    input  wire       session_end_flag,
    input  wire       session_valid_flag,
    input  wire       a_device_supply_valid_flag,
    input  wire       faultIn,
    input  wire [1:0] lineState,
    input  wire       cableIdLevel,
    input  wire       altSource,
    input  wire       hostDisconnectRaw,
    // Configuration bits
    input  wire       external_indicator_select_bit,
    input  wire       indicator_complement_bit,
    input  wire       indicator_passthrough_bit,
    input  wire       vbusRiseEnable,
    input  wire       vbusFallEnable,
    input  wire       host_disc_rise_enable,
    input  wire       host_disc_fall_enable,
    input  wire       altRiseEnable,
    input  wire       altFallEnable,
    input  wire       plus_line_pulldown_bit,
    input  wire       minus_line_pulldown_bit,
    // Receiver
    input  wire       syncDetect,
    input  wire       rxByteValid,
    input  wire [7:0] rxByte,
    input  wire       rxErrorDetect,
    input  wire       rxEnd,
    // Link side of the ULPI bus
    input  wire [7:0] ulpiDataIn,
    input  wire       ulpiStp,
    input  wire       regOpDone,
    output reg        ulpiDir,
    output reg        ulpiNxt,
    output reg  [7:0] ulpiDataOut,
    output reg        ulpiDataOe,
    // Register access status
    output reg        regAbort,
    output reg        regExtended
);
    localparam S_IDLE = 3'h0;
    localparam S_TURN = 3'h1;
    localparam S_CMD  = 3'h2;
    localparam S_RX   = 3'h3;
    localparam S_ERR  = 3'h4;
    localparam S_DONE = 3'h5;

    function [7:0] packStatus;
        input [1:0] line;
        input [1:0] vbus;
        input [1:0] evt;
        input       id;
        input       alt;
        begin
            packStatus = `UPS_BYTE_RESET;
            packStatus[`UPS_FLD_LINE_LSB +: 2] = line;
            packStatus[`UPS_FLD_VBUS_LSB +: 2] = vbus;
            packStatus[`UPS_FLD_EVT_LSB +: 2]  = evt;
            packStatus[`UPS_FLD_ID_BIT]        = id;
            packStatus[`UPS_FLD_ALT_BIT]       = alt;
        end
    endfunction

    wire [1:0] vbusState;

    ups_vbus_enc uVbusEnc (
        .session_end_flag              (session_end_flag),
        .session_valid_flag            (session_valid_flag),
        .a_device_supply_valid_flag    (a_device_supply_valid_flag),
        .faultIn                       (faultIn),
        .external_indicator_select_bit (external_indicator_select_bit),
        .indicator_complement_bit      (indicator_complement_bit),
        .indicator_passthrough_bit     (indicator_passthrough_bit),
        .vbusState                     (vbusState)
    );

    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [7:0] sent_reg;
    reg        pending_reg;
    reg        rxActive_reg;
    reg        rxError_reg;
    reg        hostDisc_reg;
    reg        alt_reg;
    reg        altSrc_reg;
    reg        regBusy_reg;

    wire       hostMode    = plus_line_pulldown_bit & minus_line_pulldown_bit;
    wire       hostDiscNow = hostMode & hostDisconnectRaw;
    wire [1:0] evtNow      = hostDisc_reg ? `UPS_EVT_HOST_DISC :
                             rxError_reg  ? `UPS_EVT_ERROR :
                             rxActive_reg ? `UPS_EVT_ACTIVE : `UPS_EVT_IDLE;
    wire [7:0] statusNow   = packStatus(lineState, vbusState, evtNow, cableIdLevel, alt_reg);
    wire [1:0] vbusSent    = sent_reg[`UPS_FLD_VBUS_LSB +: 2];

    // Supply, disconnect and alternate changes are reported only per enabled edge, except a disconnect cleared by leaving host mode
    wire vbusTrig  = ((vbusState > vbusSent) & vbusRiseEnable) |
                     ((vbusState < vbusSent) & vbusFallEnable);
    wire discTrig  = (hostDiscNow & ~hostDisc_reg & host_disc_rise_enable) |
                     (~hostDiscNow & hostDisc_reg & host_disc_fall_enable);
    wire altTrig   = (altSource & ~altSrc_reg & altRiseEnable) |
                     (~altSource & altSrc_reg & altFallEnable);
    wire lineTrig  = (lineState != sent_reg[`UPS_FLD_LINE_LSB +: 2]) |
                     (cableIdLevel != sent_reg[`UPS_FLD_ID_BIT]);
    wire evtTrig   = evtNow != sent_reg[`UPS_FLD_EVT_LSB +: 2];
    wire trigger   = vbusTrig | discTrig | altTrig | lineTrig | evtTrig;
    wire needCmd   = pending_reg | trigger;

    // Register command seen on the bus while the link owns it
    wire regCmdSeen = ~ulpiDir & ((ulpiDataIn[7:6] == `UPS_CMD_TYPE_WRITE) |
                                  (ulpiDataIn[7:6] == `UPS_CMD_TYPE_READ));

    reg       dirNext;
    reg       nxtNext;
    reg [7:0] dataNext;
    reg       oeNext;
    reg       sendNow;

    always @* begin
        state_next = state_reg;
        dirNext    = ulpiDir;
        nxtNext    = 1'b0;
        dataNext   = ulpiDataOut;
        oeNext     = 1'b0;
        sendNow    = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (syncDetect) begin
                    dirNext = 1'b1;
                    if (DIR_NXT_START != 0) begin
                        nxtNext    = 1'b1;
                        state_next = S_RX;
                    end else begin
                        state_next = S_TURN;
                    end
                end else if (needCmd) begin
                    dirNext    = 1'b1;
                    state_next = S_TURN;
                end
            end
            S_TURN: begin
                // Turnaround cycle: bus released by link before data appears
                state_next = S_CMD;
            end
            S_CMD: begin
                oeNext   = 1'b1;
                dataNext = statusNow;
                sendNow  = 1'b1;
                state_next = rxActive_reg ? S_RX : S_DONE;
            end
            S_RX: begin
                oeNext = 1'b1;
                if (rxEnd) begin
                    dirNext    = 1'b0;
                    oeNext     = 1'b0;
                    state_next = S_IDLE;
                end else if (rxErrorDetect) begin
                    // NXT drops here; this gap carries a status byte, the error byte follows
                    dataNext   = statusNow;
                    sendNow    = 1'b1;
                    state_next = S_ERR;
                end else if (rxByteValid) begin
                    nxtNext  = 1'b1;
                    dataNext = rxByte;
                end else begin
                    // Every gap with NXT low carries a status byte, never stale packet data
                    dataNext = statusNow;
                    sendNow  = 1'b1;
                end
            end
            S_ERR: begin
                oeNext     = 1'b1;
                dataNext   = statusNow;
                sendNow    = 1'b1;
                state_next = S_RX;
            end
            S_DONE: begin
                if (trigger) begin
                    state_next = S_CMD;
                end else begin
                    dirNext    = 1'b0;
                    state_next = S_IDLE;
                end
            end
            default: begin
                dirNext    = 1'b0;
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            state_reg    <= `UPS_STATE_RESET;
            sent_reg     <= `UPS_BYTE_RESET;
            pending_reg  <= 1'b0;
            rxActive_reg <= 1'b0;
            rxError_reg  <= 1'b0;
            hostDisc_reg <= 1'b0;
            alt_reg      <= 1'b0;
            altSrc_reg   <= 1'b0;
            regBusy_reg  <= 1'b0;
            ulpiDir      <= 1'b0;
            ulpiNxt      <= 1'b0;
            ulpiDataOut  <= `UPS_BYTE_RESET;
            ulpiDataOe   <= 1'b0;
            regAbort     <= 1'b0;
            regExtended  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            ulpiDir     <= dirNext;
            ulpiNxt     <= nxtNext;
            ulpiDataOut <= dataNext;
            ulpiDataOe  <= oeNext;
            altSrc_reg  <= altSource;
            if (altTrig) begin
                alt_reg <= 1'b1;
            end else if (sendNow) begin
                alt_reg <= 1'b0;
            end
            if (discTrig) begin
                hostDisc_reg <= hostDiscNow;
            end else if (!hostMode) begin
                hostDisc_reg <= 1'b0;
            end
            // Activity and error stick until the packet ends
            if (syncDetect && state_reg == S_IDLE) begin
                rxActive_reg <= 1'b1;
            end else if (rxEnd) begin
                rxActive_reg <= 1'b0;
            end
            if (rxErrorDetect && state_reg == S_RX) begin
                rxError_reg <= 1'b1;
            end else if (rxEnd) begin
                rxError_reg <= 1'b0;
            end
            // A new alternate edge in the send cycle keeps the request alive
            if (sendNow) begin
                sent_reg    <= statusNow;
                pending_reg <= altTrig;
            end else if (trigger) begin
                pending_reg <= 1'b1;
            end
            // Extended address is just a reserved immediate code
            if (regCmdSeen && !regBusy_reg) begin
                regBusy_reg <= 1'b1;
                regExtended <= ulpiDataIn[5:0] == `UPS_CMD_EXT_ADDR;
            end else if (dirNext && !ulpiDir && regBusy_reg) begin
                regBusy_reg <= 1'b0;
            end else if (ulpiStp || regOpDone) begin
                regBusy_reg <= 1'b0;
            end
            regAbort <= dirNext & ~ulpiDir & regBusy_reg;
        end
    end
endmodule // ups_phy_status

`default_nettype wire

//--- design/ups_vbus_enc.v
`timescale 1ns/1ps
`default_nettype none
`include "ups_regs.vh"

module ups_vbus_enc (
    // Comparator outputs
    input  wire       session_end_flag,
    input  wire       session_valid_flag,
    input  wire       a_device_supply_valid_flag,
    // Shared sense/fault pin selection
    input  wire       faultIn,
    input  wire       external_indicator_select_bit,
    input  wire       indicator_complement_bit,
    input  wire       indicator_passthrough_bit,
    // Encoded state
    output reg  [1:0] vbusState
);
    reg upperFlag;

    always @* begin
        // One pin: either the comparator or the external fault drives the top level
        if (external_indicator_select_bit) begin
            upperFlag = indicator_passthrough_bit ?
                        (faultIn ^ indicator_complement_bit) : a_device_supply_valid_flag;
        end else begin
            upperFlag = a_device_supply_valid_flag;
        end
        if (upperFlag) begin
            vbusState = `UPS_VBUS_A_VALID;
        end else if (session_valid_flag) begin
            vbusState = `UPS_VBUS_VLD_TO_A;
        end else if (session_end_flag) begin
            vbusState = `UPS_VBUS_BELOW_END;
        end else begin
            vbusState = `UPS_VBUS_END_TO_VLD;
        end
    end
endmodule // ups_vbus_enc

`default_nettype wire

//--- include/ups_regs.vh
`ifndef UPS_REGS_VH
`define UPS_REGS_VH

// Supply-voltage state encodings
`define UPS_VBUS_BELOW_END   2'b00
`define UPS_VBUS_END_TO_VLD  2'b01
`define UPS_VBUS_VLD_TO_A    2'b10
`define UPS_VBUS_A_VALID     2'b11

// Receive-event encodings
`define UPS_EVT_IDLE         2'b00
`define UPS_EVT_ACTIVE       2'b01
`define UPS_EVT_ERROR        2'b11
`define UPS_EVT_HOST_DISC    2'b10

// Receive-status byte field positions
`define UPS_FLD_LINE_LSB     0
`define UPS_FLD_VBUS_LSB     2
`define UPS_FLD_EVT_LSB      4
`define UPS_FLD_ID_BIT       6
`define UPS_FLD_ALT_BIT      7

// Transmit command codes from the link
`define UPS_CMD_TYPE_WRITE   2'b10
`define UPS_CMD_TYPE_READ    2'b11
`define UPS_CMD_EXT_ADDR     6'h2F

// Reset values
`define UPS_BYTE_RESET       8'h00
`define UPS_STATE_RESET      3'h0

`endif

//--- tb/test_ups_phy_status.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); bad_count++; end end
module test_ups_phy_status;
    logic core_clk = 1'b0, reset = 1'b1;
    logic session_end_flag, session_valid_flag, a_device_supply_valid_flag, faultIn, cableIdLevel, altSource;
    logic hostDisconnectRaw, external_indicator_select_bit, indicator_complement_bit, indicator_passthrough_bit;
    logic vbusRiseEnable, vbusFallEnable, host_disc_rise_enable, host_disc_fall_enable, altRiseEnable, altFallEnable;
    logic plus_line_pulldown_bit, minus_line_pulldown_bit, syncDetect, rxByteValid, rxErrorDetect, rxEnd, ulpiStp;
    logic regOpDone, cmdReq, rxActive, pktBad, ulpiDir, ulpiNxt, ulpiDataOe, regAbort, regExtended;
    logic [1:0] lineState;
    logic [7:0] rxByte, ulpiDataIn, ulpiDataOut, cmdByte, lastStatus, lastData, ex;
    logic [31:0] seed = 32'h0000_580e, r;
    int statusCount, pktBytes, retries, cnt, k, bad_count = 0, n_checks = 0;
    ups_phy_status #(.DIR_NXT_START(1)) u_ups_phy_status (.*);
    ups_link_model u_ups_link_model (.*);
    always #5 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [1:0] exp_vbus(input logic se, sv, av);
        return av ? 2'h3 : sv ? 2'h2 : se ? 2'h0 : 2'h1;
    endfunction
    task automatic tally_and_finish();
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Quiet means dir low long enough that no status byte can still be in flight
    task automatic settle();
        int q;
        q = 0;
        for (int i = 0; i < 80 && q < 4; i++) begin
            @(posedge core_clk);
            q = ulpiDir ? 0 : q + 1;
        end
        if (q < 4) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic step_line();
        @(posedge core_clk) lineState <= lineState ^ 2'h1;
        settle();
    endtask
    // Far-side line activity during reset and chirp, shortened to one settle per state
    task automatic line_to(input logic [1:0] ls);
        @(posedge core_clk) lineState <= ls;
        settle();
        `CHK("line state", ls, lastStatus[1:0])
    endtask
    task automatic rx_packet(input int n, input logic err);
        logic [7:0] b;
        @(posedge core_clk) syncDetect <= 1'b1;
        @(posedge core_clk) syncDetect <= 1'b0;
        for (int i = 0; i < n; i++) begin
            b = 8'(rnd());
            @(posedge core_clk) rxByteValid <= 1'b1;
            rxByte <= b;
        end
        @(posedge core_clk) rxByteValid <= 1'b0;
        rxErrorDetect <= err;
        @(posedge core_clk) rxErrorDetect <= 1'b0;
        tick(6);
        @(posedge core_clk) rxEnd <= 1'b1;
        @(posedge core_clk) rxEnd <= 1'b0;
        settle();
        `CHK("packet bytes", n, pktBytes)
        `CHK("last data", b, lastData)
        `CHK("packet dropped", err, pktBad)
        `CHK("activity ended", 1'b0, rxActive)
    endtask
    initial begin
        {session_end_flag, session_valid_flag, a_device_supply_valid_flag, faultIn, cableIdLevel, altSource,
         hostDisconnectRaw, external_indicator_select_bit, indicator_complement_bit, indicator_passthrough_bit,
         vbusRiseEnable, vbusFallEnable, host_disc_rise_enable, host_disc_fall_enable, altRiseEnable,
         altFallEnable, plus_line_pulldown_bit, minus_line_pulldown_bit, syncDetect, rxByteValid, rxErrorDetect,
         rxEnd, ulpiStp, regOpDone, cmdReq, lineState, rxByte, cmdByte} = '0;
        tick(10);
        reset <= 1'b0;
        settle();
        @(posedge core_clk) {vbusRiseEnable, vbusFallEnable} <= 2'h3;
        {host_disc_rise_enable, host_disc_fall_enable} <= 2'h3;
        for (k = 0; k < 40; k++) begin
            r = rnd();
            cnt = statusCount;
            @(posedge core_clk);
            {hostDisconnectRaw, cableIdLevel, a_device_supply_valid_flag, session_valid_flag,
             session_end_flag} <= r[4:0];
            plus_line_pulldown_bit <= r[5];
            minus_line_pulldown_bit <= r[5] | r[6];
            altSource <= r[9];
            lineState <= lineState ^ ((r[8:7] == 2'h0) ? 2'h1 : r[8:7]);
            settle();
            ex = {1'b0, r[3], (r[4] && r[5]) ? 2'h2 : 2'h0, exp_vbus(r[0], r[1], r[2]), lineState};
            `CHK("status sent", 1'b1, statusCount > cnt)
            `CHK("status byte", ex, lastStatus)
        end
        @(posedge core_clk) {altRiseEnable, altSource} <= 2'h2;
        settle();
        @(posedge core_clk) altSource <= 1'b1;
        settle();
        `CHK("alternate bit", 1'b1, lastStatus[7])
        @(posedge core_clk) {vbusRiseEnable, vbusFallEnable, plus_line_pulldown_bit, minus_line_pulldown_bit} <= '0;
        settle();
        cnt = statusCount;
        @(posedge core_clk) a_device_supply_valid_flag <= ~a_device_supply_valid_flag;
        settle();
        `CHK("masked supply edge", cnt, statusCount)
        step_line();
        `CHK("late supply state", exp_vbus(session_end_flag, session_valid_flag, a_device_supply_valid_flag),
             lastStatus[3:2])
        @(posedge core_clk) {external_indicator_select_bit, indicator_passthrough_bit} <= 2'h3;
        {indicator_complement_bit, faultIn, a_device_supply_valid_flag} <= 3'h4;
        step_line();
        `CHK("fault as supply", 2'h3, lastStatus[3:2])
        @(posedge core_clk) {external_indicator_select_bit, indicator_passthrough_bit} <= 2'h0;
        line_to(2'h1); // full-speed attach shows the plus line high
        line_to(2'h0); // host drives SE0
        line_to(2'h2); // peripheral Chirp K
        for (k = 0; k < 6; k++) begin // host K-J-K-J-K-J
            line_to(k[0] ? 2'h1 : 2'h2);
        end
        rx_packet(1, 1'b0);
        rx_packet(5, 1'b1);
        rx_packet(rnd() % 8 + 1, 1'b0);
        @(posedge core_clk) cmdByte <= 8'hAF;
        cmdReq <= 1'b1;
        @(posedge core_clk) cmdReq <= 1'b0;
        tick(3);
        `CHK("extended address", 1'b1, regExtended)
        step_line();
        @(posedge core_clk) regOpDone <= 1'b1;
        @(posedge core_clk) regOpDone <= 1'b0;
        `CHK("aborted access retried", 1'b1, retries > 0)
        cmdByte <= 8'hC5;
        cmdReq <= 1'b1;
        @(posedge core_clk) cmdReq <= 1'b0;
        tick(3);
        `CHK("immediate address", 1'b0, regExtended)
        @(posedge core_clk) regOpDone <= 1'b1;
        @(posedge core_clk) regOpDone <= 1'b0;
        tally_and_finish();
    end
endmodule // test_ups_phy_status
`default_nettype wire

//--- tb/ups_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ups_link_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Device side of the bus
    input  wire logic       ulpiDir,
    input  wire logic       ulpiNxt,
    input  wire logic       ulpiDataOe,
    input  wire logic [7:0] ulpiDataOut,
    input  wire logic       regAbort,
    input  wire logic       regOpDone,
    output logic      [7:0] ulpiDataIn,
    // Bench control and observation
    input  wire logic       cmdReq,
    input  wire logic [7:0] cmdByte,
    output logic      [7:0] lastStatus,
    output logic      [7:0] lastData,
    output int              statusCount,
    output int              pktBytes,
    output int              retries,
    output logic            rxActive,
    output logic            pktBad
);
    logic       dirQ;
    logic       pending;
    logic [5:0] junk;
    // Released bus toggles each cycle but never looks like a command
    assign ulpiDataIn = ulpiDir ? {2'h1, junk} : (pending ? cmdByte : 8'h00);
    always @(posedge core_clk) begin
        if (reset) begin
            {dirQ, pending, junk, lastStatus, lastData, rxActive, pktBad} <= '0;
            statusCount <= 0;
            pktBytes <= 0;
            retries <= 0;
        end else begin
            dirQ <= ulpiDir;
            junk <= ~junk;
            if (cmdReq)
                pending <= 1'b1;
            else if (regOpDone)
                pending <= 1'b0;
            if (regAbort)
                retries <= retries + 1;
            if (ulpiDir && ulpiNxt && !dirQ) begin
                rxActive <= 1'b1;
                pktBytes <= 0;
                pktBad <= 1'b0;
            end else if (ulpiDataOe && ulpiNxt) begin
                pktBytes <= pktBytes + 1;
                lastData <= ulpiDataOut;
            end else if (ulpiDataOe) begin
                lastStatus <= ulpiDataOut;
                statusCount <= statusCount + 1;
                rxActive <= ulpiDataOut[4];
                if (ulpiDataOut[5:4] == 2'h3)
                    pktBad <= 1'b1;
            end
            if (!ulpiDir)
                rxActive <= 1'b0;
        end
    end
endmodule // ups_link_model
`default_nettype wire

//--- tb/ups_phy_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ups_phy_status_monitor #(
    parameter DIR_NXT_START = 1
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset,
    // Stimulus seen by the block
    input wire logic [1:0] lineState,
    input wire logic       syncDetect,
    input wire logic       rxErrorDetect,
    input wire logic       rxEnd,
    input wire logic       plus_line_pulldown_bit,
    input wire logic       minus_line_pulldown_bit,
    // Bus outputs
    input wire logic       ulpiDir,
    input wire logic       ulpiNxt,
    input wire logic [7:0] ulpiDataOut,
    input wire logic       ulpiDataOe,
    input wire logic       regAbort
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_line_byte; !ulpiDir && !syncDetect && lineState != $past(lineState)
        |-> ##[2:6] (ulpiDataOe && !ulpiNxt && ulpiDataOut[1:0] == lineState); endproperty
    a_line_byte: assert property (p_line_byte) else $error("line change not reported");
    property p_sync_start; DIR_NXT_START == 1 && syncDetect && !ulpiDir |=> ulpiDir && ulpiNxt; endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync not signalled by dir and nxt");
    property p_err_status; rxErrorDetect && ulpiDir && !rxEnd
        |=> !ulpiNxt ##[1:4] (ulpiDataOe && ulpiDataOut[5:4] == 2'h3); endproperty
    a_err_status: assert property (p_err_status) else $error("receive error not reported");
    property p_rx_end; rxEnd && ulpiDir |=> !ulpiDir ##[1:6] (ulpiDataOe && ulpiDataOut[5:4] == 2'h0); endproperty
    a_rx_end: assert property (p_rx_end) else $error("end of receive not reported idle");
    property p_abort; regAbort |-> $rose(ulpiDir); endproperty
    a_abort: assert property (p_abort) else $error("abort without dir rising");
    property p_disc_gate; ulpiDataOe && !ulpiNxt && !(plus_line_pulldown_bit && minus_line_pulldown_bit)
        |-> ulpiDataOut[5:4] != 2'h2; endproperty
    a_disc_gate: assert property (p_disc_gate) else $error("disconnect outside host mode");
    // Data may only be driven after a turnaround cycle with dir already high
    property p_turnaround; ulpiDataOe |-> ulpiDir && $past(ulpiDir); endproperty
    a_turnaround: assert property (p_turnaround) else $error("data driven without turnaround");
    property p_nxt_dir; ulpiNxt |-> ulpiDir; endproperty
    a_nxt_dir: assert property (p_nxt_dir) else $error("nxt without dir");
    c_status: cover property (ulpiDataOe && !ulpiNxt);
    c_rx_data: cover property (ulpiDataOe && ulpiNxt);
    c_abort: cover property (regAbort);
endmodule // ups_phy_status_monitor
bind ups_phy_status ups_phy_status_monitor #(.DIR_NXT_START(DIR_NXT_START)) u_mon (.*);
`default_nettype wire
